// File: core/ivt_map.svh
// Offsets, field positions, reset values and fixed trap figures
// Assumes byte addresses on a 32-bit APB, one aligned word per register
`ifndef IVT_MAP_SVH
`define IVT_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define IVT_ADDR_W 12
`define IVT_CTRL_BASE 12'h000
`define IVT_XSEL_BASE 12'h0E0
`define IVT_XSEL_LAST 12'h0EC
`define IVT_TFR_OFF 12'h100
`define IVT_STAT_OFF 12'h104

// ----------------------------------------
// Source control word layout
// ----------------------------------------
`define IVT_LVL_MSB 3
`define IVT_EN_BIT 6
`define IVT_FLAG_BIT 7
`define IVT_CTRL_RST 8'h00
`define IVT_XSEL_RST 16'h0000

// ----------------------------------------
// Trap flag and status layout
// ----------------------------------------
`define IVT_TFR_W 9
`define IVT_TFR_NMI 8
`define IVT_TFR_STKOF 7
`define IVT_TFR_STKUF 6
`define IVT_TFR_B_MSB 5
`define IVT_STAT_ACT_A 4
`define IVT_STAT_ACT_B 5
`define IVT_STAT_MASK_LSB 16

// ----------------------------------------
// Trap numbers and levels
// ----------------------------------------
`define IVT_SRC_TRAP_BASE 8'h10
`define IVT_TRAPN_NMI 8'h02
`define IVT_TRAPN_STKOF 8'h04
`define IVT_TRAPN_STKUF 8'h06
`define IVT_TRAPN_B 8'h0A
`define IVT_TRAP_LEVEL 4'hF
`define IVT_TSRC_B 6'h03

`endif

// File: core/ivt_pkg.sv
// Types shared by the vectoring and trap logic
// Assumes the CPU core and trap sources run on pclk
`default_nettype none
package ivt_pkg;

    // Hardware trap causes, one bit each, same order as the trap flags
    typedef struct packed {
        logic nmi;
        logic stkof;
        logic stkuf;
        logic undopc;
        logic mactrp;
        logic prtflt;
        logic illopa;
        logic illina;
        logic illbus;
    } ivt_trap_evt_t;

    // Entry request offered to the CPU core
    typedef struct packed {
        logic valid;
        logic is_trap;
        logic [3:0] level;
        logic [5:0] src;
        logic [15:0] vector;
    } ivt_cpu_req_t;

endpackage
`default_nettype wire

// File: core/ivt_source_slot.sv
// One interrupt source: request flag, enable flag and priority level
// Assumes set pulses and ack come from logic on pclk
`timescale 1ns/10ps
`default_nettype none
`include "ivt_map.svh"

module ivt_source_slot (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    input wire logic req_set,
    input wire logic ack_clr,
    output logic [7:0] ctrl_q
);
    logic flag_reg;
    logic en_reg;
    logic [3:0] lvl_reg;

    // ----------------------------------------
    // Request flag, set wins over any clear
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= 1'(`IVT_CTRL_RST >> `IVT_FLAG_BIT);
        end else if (req_set) begin
            flag_reg <= 1'b1;
        end else if (ack_clr) begin
            flag_reg <= 1'b0;
        end else if (wr_en) begin
            flag_reg <= wr_data[`IVT_FLAG_BIT];
        end
    end

    // ----------------------------------------
    // Enable and priority level
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_reg <= 1'b0;
            lvl_reg <= 4'h0;
        end else if (wr_en) begin
            en_reg <= wr_data[`IVT_EN_BIT];
            lvl_reg <= wr_data[`IVT_LVL_MSB:0];
        end
    end

    assign ctrl_q = {flag_reg, en_reg, 2'b00, lvl_reg};

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    flag_set_a: assert property (req_set |=> flag_reg)
        else $error("request flag not set after source request");
    lvl_keep_a: assert property (!wr_en |=> $stable(lvl_reg) && $stable(en_reg))
        else $error("level or enable changed without a write");

endmodule
`default_nettype wire

// File: core/ivt_top.sv
// Interrupt vectoring and hardware trap logic with an APB register slave
// Assumes source requests, trap causes and CPU handshakes are on pclk
`timescale 1ns/10ps
`default_nettype none
`include "ivt_map.svh"

module ivt_top #(
    parameter int NUM_SRC = 56,
    parameter int XP_FIRST = 48
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_SRC-1:0] src_req,
    input wire logic [31:0] xsrc_req,
    input wire ivt_pkg::ivt_trap_evt_t trap_evt,
    output ivt_pkg::ivt_cpu_req_t cpu_req,
    input wire logic cpu_ack,
    input wire logic cpu_ret,
    output logic pec_allow
);
    if (NUM_SRC < XP_FIRST + 4 || NUM_SRC > 56 || XP_FIRST < 0) begin : g_bad_cfg
        $error("NUM_SRC or XP_FIRST out of range");
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [3:0] top_bit(input logic [15:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 0; k < 16; k++) begin
            if (m[k]) begin
                r = 4'(k);
            end
        end
        return r;
    endfunction

    function automatic logic is_ctrl(input logic [11:0] a);
        return (a < 12'(NUM_SRC * 4)) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic is_xsel(input logic [11:0] a);
        return (a >= `IVT_XSEL_BASE) && (a <= `IVT_XSEL_LAST) && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [15:0] src_vector(input logic [5:0] s);
        logic [7:0] tn;
        tn = `IVT_SRC_TRAP_BASE + {2'b00, s};
        return {6'h00, tn, 2'b00};
    endfunction

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_q [NUM_SRC];
    logic [NUM_SRC-1:0] slot_wr;
    logic [NUM_SRC-1:0] slot_set;
    logic [NUM_SRC-1:0] slot_ack;
    logic [15:0] xsel_reg [4];
    logic [3:0] xp_req;
    logic [`IVT_TFR_W-1:0] tfr_reg;
    logic [2:0] pend_a_reg;
    logic pend_b_reg;
    logic act_a_reg;
    logic act_b_reg;
    logic [15:0] act_mask_reg;
    logic [3:0] cur_level;
    logic [1:0] act_tprio;
    logic [`IVT_TFR_W-1:0] evt_bits;
    ivt_pkg::ivt_cpu_req_t sel;
    logic [3:0] best_lvl;
    logic wr_fire;
    logic take;
    logic [5:0] wr_idx;

    assign evt_bits = trap_evt;
    assign wr_fire = psel && penable && pwrite && pready;
    assign take = cpu_ack && cpu_req.valid;
    assign cur_level = top_bit(act_mask_reg);
    assign act_tprio = act_a_reg ? 2'd2 : (act_b_reg ? 2'd1 : 2'd0);
    assign wr_idx = paddr[7:2];

    // ----------------------------------------
    // Source slots
    // ----------------------------------------
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_slot
        if (i >= XP_FIRST && i < XP_FIRST + 4) begin : g_xp
            assign slot_set[i] = src_req[i] | xp_req[i - XP_FIRST];
        end else begin : g_plain
            assign slot_set[i] = src_req[i];
        end
        assign slot_wr[i] = wr_fire && is_ctrl(paddr) && (wr_idx == 6'(i));
        assign slot_ack[i] = take && !cpu_req.is_trap && (cpu_req.src == 6'(i));
        ivt_source_slot u_slot (
            .pclk(pclk),
            .presetn(presetn),
            .wr_en(slot_wr[i]),
            .wr_data(pwdata[7:0]),
            .req_set(slot_set[i]),
            .ack_clr(slot_ack[i]),
            .ctrl_q(ctrl_q[i])
        );
    end

    // ----------------------------------------
    // Shared vector select registers
    // ----------------------------------------
    for (genvar x = 0; x < 4; x++) begin : g_xsel
        logic xwr;
        assign xwr = wr_fire && is_xsel(paddr) && (paddr[3:2] == 2'(x));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                xsel_reg[x] <= `IVT_XSEL_RST;
            end else begin
                if (xwr) begin
                    xsel_reg[x][15:8] <= pwdata[15:8];
                end
                xsel_reg[x][7:0] <= (xwr ? pwdata[7:0] : xsel_reg[x][7:0])
                    | xsrc_req[8*x +: 8];
            end
        end
        assign xp_req[x] = |(xsel_reg[x][15:8] & xsel_reg[x][7:0]);
    end

    // ----------------------------------------
    // Trap flags and pending traps
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tfr_reg <= '0;
        end else if (wr_fire && paddr == `IVT_TFR_OFF) begin
            tfr_reg <= (tfr_reg & pwdata[`IVT_TFR_W-1:0]) | evt_bits;
        end else begin
            tfr_reg <= tfr_reg | evt_bits;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_a_reg <= 3'b000;
            pend_b_reg <= 1'b0;
        end else begin
            for (int k = 0; k < 3; k++) begin
                if (evt_bits[`IVT_TFR_NMI - k]) begin
                    pend_a_reg[2-k] <= 1'b1;
                end else if (take && cpu_req.is_trap && cpu_req.src == 6'(k)) begin
                    pend_a_reg[2-k] <= 1'b0;
                end
            end
            if (|evt_bits[`IVT_TFR_B_MSB:0]) begin
                pend_b_reg <= 1'b1;
            end else if (take && cpu_req.is_trap && cpu_req.src == `IVT_TSRC_B) begin
                pend_b_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Services in progress
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_a_reg <= 1'b0;
            act_b_reg <= 1'b0;
            act_mask_reg <= 16'h0000;
        end else begin
            if (cpu_ret) begin
                if (act_a_reg) begin
                    act_a_reg <= 1'b0;
                end else if (act_b_reg) begin
                    act_b_reg <= 1'b0;
                end else begin
                    act_mask_reg[cur_level] <= 1'b0;
                end
            end
            if (take && cpu_req.is_trap) begin
                if (cpu_req.src == `IVT_TSRC_B) begin
                    act_b_reg <= 1'b1;
                end else begin
                    act_a_reg <= 1'b1;
                end
            end else if (take) begin
                act_mask_reg[cpu_req.level] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // Entry selection
    // ----------------------------------------
    always_comb begin
        sel = '0;
        best_lvl = cur_level;
        if (pend_a_reg != 3'b000 && act_tprio < 2'd2) begin
            sel.valid = 1'b1;
            sel.is_trap = 1'b1;
            sel.level = `IVT_TRAP_LEVEL;
            if (pend_a_reg[2]) begin
                sel.src = 6'h00;
                sel.vector = {6'h00, `IVT_TRAPN_NMI, 2'b00};
            end else if (pend_a_reg[1]) begin
                sel.src = 6'h01;
                sel.vector = {6'h00, `IVT_TRAPN_STKOF, 2'b00};
            end else begin
                sel.src = 6'h02;
                sel.vector = {6'h00, `IVT_TRAPN_STKUF, 2'b00};
            end
        end else if (pend_b_reg && act_tprio == 2'd0) begin
            sel.valid = 1'b1;
            sel.is_trap = 1'b1;
            sel.level = `IVT_TRAP_LEVEL;
            sel.src = `IVT_TSRC_B;
            sel.vector = {6'h00, `IVT_TRAPN_B, 2'b00};
        end else if (act_tprio == 2'd0) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (ctrl_q[i][`IVT_FLAG_BIT] && ctrl_q[i][`IVT_EN_BIT]
                    && ctrl_q[i][`IVT_LVL_MSB:0] > best_lvl) begin
                    best_lvl = ctrl_q[i][`IVT_LVL_MSB:0];
                    sel.valid = 1'b1;
                    sel.level = best_lvl;
                    sel.src = 6'(i);
                    sel.vector = src_vector(6'(i));
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_req <= '0;
            pec_allow <= 1'b0;
        end else begin
            cpu_req <= sel;
            cpu_req.valid <= sel.valid && !take && !cpu_ret;
            pec_allow <= (act_tprio == 2'd0);
        end
    end

    // ----------------------------------------
    // APB slave
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            if (psel && !penable) begin
                if (is_ctrl(paddr)) begin
                    prdata <= {24'h000000, ctrl_q[wr_idx]};
                end else if (is_xsel(paddr)) begin
                    prdata <= {16'h0000, xsel_reg[paddr[3:2]]};
                end else if (paddr == `IVT_TFR_OFF) begin
                    prdata <= {23'h000000, tfr_reg};
                end else if (paddr == `IVT_STAT_OFF) begin
                    prdata <= {act_mask_reg, 10'h000, act_b_reg, act_a_reg, cur_level};
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence trap_offered;
        cpu_req.valid && cpu_req.is_trap;
    endsequence

    sequence int_offered;
        cpu_req.valid && !cpu_req.is_trap;
    endsequence

    src_vector_a: assert property (int_offered |-> cpu_req.vector == src_vector(cpu_req.src))
        else $error("interrupt vector is not four times its trap number");
    trap_unmasked_a: assert property ($rose(pend_a_reg[2]) && !act_a_reg
        |-> ##[0:3] trap_offered)
        else $error("pending trap not offered");
    trap_level_a: assert property (trap_offered |-> cpu_req.level == `IVT_TRAP_LEVEL
        && cpu_req.vector[1:0] == 2'b00 && cpu_req.vector[15:10] == 6'h00)
        else $error("trap entry has wrong level or vector");
    tfr_set_a: assert property (trap_evt.nmi |=> tfr_reg[`IVT_TFR_NMI] ##1 tfr_reg[`IVT_TFR_NMI]
        || $past(wr_fire))
        else $error("trap flag not set by trap cause");
    trap_preempt_a: assert property (pend_b_reg && act_tprio == 2'd0 && act_mask_reg != 16'h0000
        && !cpu_ret && !take |-> ##[1:3] trap_offered)
        else $error("trap did not preempt interrupt service");
    trap_block_a: assert property ((act_a_reg || act_b_reg)
        |=> !(cpu_req.valid && !cpu_req.is_trap) && !pec_allow)
        else $error("interrupt or transfer offered during trap service");
    level_above_a: assert property (int_offered |-> cpu_req.level > $past(cur_level))
        else $error("interrupt offered without higher level");
    xsel_feed_a: assert property (xp_req[0] |=> ctrl_q[XP_FIRST][`IVT_FLAG_BIT])
        else $error("shared vector request not passed on");

endmodule
`default_nettype wire

// File: tb/ivt_cpu_model.sv
// CPU core model: takes offered entries after a chosen latency, ends services on request
// Assumes the vectoring block offers cpu_req on pclk and samples cpu_ack, cpu_ret there
`timescale 1ns/10ps
`default_nettype none

module ivt_cpu_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire ivt_pkg::ivt_cpu_req_t cpu_req,
    input wire logic [1:0] ack_lat,
    input wire logic ret_cmd,
    output logic cpu_ack,
    output logic cpu_ret
);
    // ----------------------------------------
    // Entry log and acknowledge timing
    // ----------------------------------------
    ivt_pkg::ivt_cpu_req_t takes[$];
    int wait_cnt;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_ack <= 1'b0;
            cpu_ret <= 1'b0;
            wait_cnt = 0;
            takes.delete();
        end else begin
            cpu_ret <= ret_cmd;
            if (cpu_ack && cpu_req.valid) begin
                // Entry taken at this edge; drop ack so it is not reused
                takes.push_back(cpu_req);
                cpu_ack <= 1'b0;
                wait_cnt = 0;
            end else if (cpu_req.valid) begin
                if (wait_cnt >= int'(ack_lat)) begin
                    cpu_ack <= 1'b1;
                end
                wait_cnt++;
            end else begin
                cpu_ack <= 1'b0;
                wait_cnt = 0;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/ivt_top_tb_top.sv
// Self-checking bench for the vectoring and trap block
// Assumes APB on pclk and a CPU core model answering the entry handshake
`timescale 1ns/10ps
`default_nettype none
`include "ivt_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
    $display("ERROR at %0t got %0h exp %0h", $time, (g), (e)); end end

module ivt_top_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [55:0] src_req = '0;
    logic [31:0] xsrc_req = 32'h0;
    ivt_pkg::ivt_trap_evt_t trap_evt = '0;
    ivt_pkg::ivt_cpu_req_t cpu_req;
    ivt_pkg::ivt_cpu_req_t tk;
    logic cpu_ack;
    logic cpu_ret;
    logic pec_allow;
    logic [1:0] ack_lat = 2'h0;
    logic ret_cmd = 1'b0;
    logic [31:0] rdat;
    logic rerr;
    int fails = 0;
    int cmp_count = 0;
    int ctrl_m[56];
    int i;
    int lv;
    int b;

    always #2 pclk = ~pclk;

    ivt_top #(.NUM_SRC(56), .XP_FIRST(48)) ivt_top_i (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_req(src_req),
        .xsrc_req(xsrc_req), .trap_evt(trap_evt), .cpu_req(cpu_req), .cpu_ack(cpu_ack),
        .cpu_ret(cpu_ret), .pec_allow(pec_allow));

    ivt_cpu_model ivt_cpu_model_i (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req),
        .ack_lat(ack_lat), .ret_cmd(ret_cmd), .cpu_ack(cpu_ack), .cpu_ret(cpu_ret));

    // ----------------------------------------
    // Bus, stimulus and closing tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) fails++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr_ctrl(input int s, input int v);
        ctrl_m[s] = v;
        apb(1'b1, 12'(4 * s), 32'(v));
    endtask

    task automatic pulse_src(input int s);
        ctrl_m[s] = ctrl_m[s] | 'h80;
        src_req[s] <= 1'b1;
        @(posedge pclk);
        src_req <= '0;
    endtask

    task automatic pulse_trap(input int t);
        trap_evt <= ivt_pkg::ivt_trap_evt_t'(9'(1 << t));
        @(posedge pclk);
        trap_evt <= '0;
    endtask

    task automatic take();
        int n;
        n = 0;
        while (ivt_cpu_model_i.takes.size() == 0 && n < 40) begin
            @(posedge pclk);
            n++;
        end
        tk = '0;
        if (ivt_cpu_model_i.takes.size() != 0) begin
            tk = ivt_cpu_model_i.takes.pop_front();
            if (!tk.is_trap) begin
                ctrl_m[tk.src] = ctrl_m[tk.src] & 'h7F;
            end
        end else begin
            fails++;
        end
    endtask

    task automatic ret();
        ret_cmd <= 1'b1;
        @(posedge pclk);
        ret_cmd <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ctrl_m[j]) ctrl_m[j] = 0;
        @(posedge pclk);
    endtask

    function automatic logic [15:0] tvec(input int t);
        return (t == 8) ? 16'h0008 : (t == 7) ? 16'h0010 : (t == 6) ? 16'h0018 : 16'h0028;
    endfunction

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (40000) @(posedge pclk);
        fails++;
        stop_test();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        void'($urandom(32'hF4CF));
        do_reset();
        for (int a = 0; a < 61; a++) begin
            apb(1'b0, (a < 56) ? 12'(4 * a) : (a < 60) ? 12'(224 + 4 * (a - 56)) : 12'h100, 0);
            `CHK(rdat, 32'h0);
        end
        apb(1'b1, 12'h0F0, 32'hFFFF_FFFF);
        `CHK(rerr, 1'b1);
        apb(1'b0, 12'h108, 0);
        `CHK({rerr, rdat}, 33'h1_0000_0000);
        for (int k = 0; k < 8; k++) begin
            i = (k == 0) ? 6 : (k == 1) ? 55 : int'($urandom % 48);
            lv = 1 + int'($urandom % 15);
            ack_lat <= 2'($urandom % 4);
            wr_ctrl(i, 'h40 | lv);
            pulse_src(i);
            take();
            `CHK(tk.vector, 16'(4 * (16 + i)));
            `CHK({tk.is_trap, tk.level, tk.src}, {1'b0, 4'(lv), 6'(i)});
            apb(1'b0, 12'(4 * i), 0);
            `CHK(rdat, 32'(ctrl_m[i]));
            ret();
        end
        wr_ctrl(20, 'h07);
        pulse_src(20);
        repeat (12) @(posedge pclk);
        `CHK(ivt_cpu_model_i.takes.size(), 0);
        apb(1'b0, 12'(4 * 20), 0);
        `CHK(rdat, 32'(ctrl_m[20]));
        wr_ctrl(20, 0);
        for (int t = 0; t < 9; t++) begin
            ack_lat <= 2'($urandom % 4);
            pulse_trap(t);
            take();
            `CHK(tk.vector, tvec(t));
            `CHK({tk.is_trap, tk.level}, 5'h1F);
            `CHK(tk.src, (t >= 6) ? 6'(8 - t) : 6'h03);
            apb(1'b0, `IVT_TFR_OFF, 0);
            `CHK(rdat, 32'(1 << t));
            apb(1'b0, `IVT_STAT_OFF, 0);
            `CHK(rdat[5:4], (t >= 6) ? 2'b01 : 2'b10);
            `CHK(pec_allow, 1'b0);
            wr_ctrl(10, 'h4F);
            pulse_src(10);
            repeat (12) @(posedge pclk);
            `CHK(ivt_cpu_model_i.takes.size(), 0);
            ret();
            `CHK(pec_allow, 1'b1);
            take();
            `CHK(tk.src, 6'd10);
            ret();
            apb(1'b1, `IVT_TFR_OFF, 0);
            apb(1'b0, `IVT_TFR_OFF, 0);
            `CHK(rdat, 32'h0);
        end
        wr_ctrl(3, 'h45);
        pulse_src(3);
        take();
        `CHK(tk.src, 6'd3);
        wr_ctrl(4, 'h45);
        pulse_src(4);
        repeat (12) @(posedge pclk);
        `CHK(ivt_cpu_model_i.takes.size(), 0);
        wr_ctrl(7, 'h46);
        pulse_src(7);
        take();
        `CHK(tk.src, 6'd7);
        apb(1'b0, `IVT_STAT_OFF, 0);
        `CHK(rdat, 32'h0060_0006);
        pulse_trap(0);
        take();
        `CHK(tk.vector, 16'h0028);
        pulse_trap(7);
        take();
        `CHK(tk.vector, 16'h0010);
        pulse_trap(5);
        repeat (12) @(posedge pclk);
        `CHK(ivt_cpu_model_i.takes.size(), 0);
        do_reset();
        for (int x = 0; x < 4; x++) begin
            b = int'($urandom % 8);
            apb(1'b1, 12'(`IVT_XSEL_BASE + 4 * x), 32'h0000_FF00);
            wr_ctrl(48 + x, 'h43);
            xsrc_req[8 * x + b] <= 1'b1;
            @(posedge pclk);
            xsrc_req <= 32'h0;
            take();
            `CHK({tk.vector, tk.src}, {16'('h100 + 4 * x), 6'(48 + x)});
            apb(1'b0, 12'(`IVT_XSEL_BASE + 4 * x), 0);
            `CHK(rdat, 32'('hFF00 | (1 << b)));
            apb(1'b1, 12'(`IVT_XSEL_BASE + 4 * x), 0);
            wr_ctrl(48 + x, 0);
            ret();
        end
        stop_test();
    end
endmodule
`default_nettype wire
